// File: design/cpu_stack_pointer.sv
// Purpose: stack pointer and 64-byte stack of the 8-bit core
// Assumes: commands come from the instruction sequencer on REF_CLK
// Notes:   one stack byte moves per enabled clock; wrap is silent by design
module cpu_stack_pointer (
    // clock, reset, enable
    input  wire logic          REF_CLK,
    input  wire logic          ARST_N,
    input  wire logic          CE,
    // command from the sequencer
    input  wire logic          CMD_VALID,
    input  wire stk_pkg::cmd_t CMD,
    input  wire stk_pkg::ctx_t CTX_IN,
    output logic               READY,
    // results
    output logic               DONE,
    output logic [7:0]         POP_DATA,
    output stk_pkg::ctx_t      CTX_OUT,
    output logic [15:0]        STACK_POINTER,
    output logic [1:0]         PRIO_LEVEL
);

    // frame length of each command; zero means no stack access
    function automatic logic [2:0] op_len(input stk_pkg::op_t op);
        unique case (op)
            stk_pkg::OP_PUSH, stk_pkg::OP_POP, stk_pkg::OP_POPCC: op_len = stk_pkg::LEN_BYTE;
            stk_pkg::OP_CALL, stk_pkg::OP_RET:                    op_len = stk_pkg::LEN_CALL;
            stk_pkg::OP_IRQ,  stk_pkg::OP_IRET:                   op_len = stk_pkg::LEN_IRQ;
            default:                                              op_len = stk_pkg::LEN_NONE;
        endcase
    endfunction

    // pick one byte of a context by frame index
    function automatic logic [7:0] ctx_byte(input stk_pkg::ctx_t c, input logic [2:0] idx);
        unique case (idx)
            stk_pkg::IDX_RET_LO: ctx_byte = c.pc[7:0];
            stk_pkg::IDX_RET_HI: ctx_byte = c.pc[15:8];
            stk_pkg::IDX_X:      ctx_byte = c.x;
            stk_pkg::IDX_A:      ctx_byte = c.a;
            default:             ctx_byte = c.flags;
        endcase
    endfunction

    // place one byte into a context by frame index
    function automatic stk_pkg::ctx_t ctx_put(input stk_pkg::ctx_t c, input logic [2:0] idx,
                                              input logic [7:0] b);
        ctx_put = c;
        unique case (idx)
            stk_pkg::IDX_RET_LO: ctx_put.pc[7:0]  = b;
            stk_pkg::IDX_RET_HI: ctx_put.pc[15:8] = b;
            stk_pkg::IDX_X:      ctx_put.x        = b;
            stk_pkg::IDX_A:      ctx_put.a        = b;
            default:             ctx_put.flags    = b;
        endcase
    endfunction

    logic [7:0]    stack_mem [0:stk_pkg::STACK_DEPTH-1];
    logic [5:0]    low_r;
    logic [5:0]    low_nxt;
    stk_pkg::op_t  op_r;
    stk_pkg::ctx_t save_r;
    stk_pkg::ctx_t save_nxt;
    stk_pkg::ctx_t rest_r;
    stk_pkg::ctx_t rest_nxt;
    logic [1:0]    lvl_req_r;
    logic [1:0]    prio_r;
    logic [1:0]    prio_nxt;
    logic [7:0]    pop_r;
    logic          done_r;

    wire logic          seq_busy;
    wire logic          seq_active;
    wire logic [2:0]    seq_step;
    wire logic          seq_last;
    wire logic          take;
    wire logic          seq_start;
    wire stk_pkg::op_t  cur_op;
    wire logic [2:0]    cur_len;
    wire logic          is_push;
    wire logic          is_pop;
    wire logic [2:0]    byte_idx;
    wire stk_pkg::ctx_t cur_save;
    wire logic [7:0]    push_byte;
    wire logic [5:0]    low_inc;
    wire logic [5:0]    low_dec;
    wire logic [7:0]    pop_byte;
    wire logic          flags_popped;
    wire logic          do_restack;
    wire logic          do_ld;

    // command acceptance; a frame in flight holds off the next command
    assign READY     = ~seq_busy;
    assign take      = CE & CMD_VALID & ~seq_busy;
    assign seq_start = take & (op_len(CMD.op) != stk_pkg::LEN_NONE);
    assign do_restack = take & (CMD.op == stk_pkg::OP_RESTACK);
    assign do_ld     = take & (CMD.op == stk_pkg::OP_LDSP);

    stk_frame_seq u_seq (
        .clk    (REF_CLK),
        .arst_n (ARST_N),
        .ce     (CE),
        .start  (seq_start),
        .len    (op_len(CMD.op)),
        .busy   (seq_busy),
        .active (seq_active),
        .step   (seq_step),
        .last   (seq_last)
    );

    // decode of the byte being moved this cycle
    assign cur_op   = seq_start ? CMD.op : op_r;
    assign cur_len  = op_len(cur_op);
    assign is_push  = seq_active & ((cur_op == stk_pkg::OP_PUSH) |
                                    (cur_op == stk_pkg::OP_CALL) |
                                    (cur_op == stk_pkg::OP_IRQ));
    assign is_pop   = seq_active & ~is_push;
    // low return byte first, pops run in reverse
    assign byte_idx = (cur_op == stk_pkg::OP_POPCC) ? stk_pkg::IDX_FLAGS :
                      is_push ? seq_step : (cur_len - 3'h1 - seq_step);

    // saved flags carry the live priority bits
    always_comb begin
        save_nxt = CTX_IN;
        save_nxt.flags[stk_pkg::FLG_I1_POS] = prio_r[1];
        save_nxt.flags[stk_pkg::FLG_I0_POS] = prio_r[0];
    end

    assign cur_save  = seq_start ? save_nxt : save_r;
    assign push_byte = (cur_op == stk_pkg::OP_PUSH) ? CMD.data : ctx_byte(cur_save, byte_idx);

    assign low_inc   = low_r + 6'h01;
    assign low_dec   = low_r - 6'h01;
    // read the location after the increment
    assign pop_byte  = stack_mem[low_inc];
    assign flags_popped = is_pop & (byte_idx == stk_pkg::IDX_FLAGS) &
                          ((cur_op == stk_pkg::OP_IRET) | (cur_op == stk_pkg::OP_POPCC));

    // fixed upper bits, only the low six move
    assign STACK_POINTER = {stk_pkg::PTR_FIXED_HI, low_r};
    assign DONE       = done_r;
    assign POP_DATA   = pop_r;
    assign CTX_OUT    = rest_r;
    assign PRIO_LEVEL = prio_r;

    // pointer next value
    always_comb begin
        low_nxt = low_r;
        if (do_restack) begin
            low_nxt = stk_pkg::PTR_LOW_RESET;
        end else if (do_ld) begin
            low_nxt = CMD.data[5:0];
        end else if (is_push) begin
            low_nxt = low_dec;
        end else if (is_pop) begin
            low_nxt = low_inc;
        end
    end

    // restored context and priority; interrupt entry sets the priority to the routine level last
    always_comb begin
        rest_nxt = rest_r;
        prio_nxt = prio_r;
        if (is_pop) begin
            rest_nxt = ctx_put(rest_r, byte_idx, pop_byte);
        end
        if (is_push & seq_last & (cur_op == stk_pkg::OP_IRQ)) begin
            prio_nxt = lvl_req_r;
        end
        if (flags_popped) begin
            prio_nxt = {pop_byte[stk_pkg::FLG_I1_POS], pop_byte[stk_pkg::FLG_I0_POS]};
        end
    end

    // control state
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            low_r     <= stk_pkg::PTR_LOW_RESET;
            op_r      <= stk_pkg::OP_PUSH;
            save_r    <= '0;
            rest_r    <= '0;
            lvl_req_r <= 2'h0;
            prio_r    <= stk_pkg::PRIO_RESET;
            pop_r     <= 8'h00;
            done_r    <= 1'b0;
        end else if (CE) begin
            low_r  <= low_nxt;
            rest_r <= rest_nxt;
            prio_r <= prio_nxt;
            done_r <= seq_last | do_restack | do_ld;
            if (seq_start) begin
                op_r      <= CMD.op;
                save_r    <= save_nxt;
                lvl_req_r <= CMD.irq_lvl;
            end
            if (is_pop) begin
                pop_r <= pop_byte;
            end
        end
    end

    // stack storage has no reset; contents are undefined until written
    always_ff @(posedge REF_CLK) begin
        // write at pointer, may overwrite on wrap
        if (CE & is_push) begin
            stack_mem[low_r] <= push_byte;
        end
    end

endmodule // cpu_stack_pointer

// File: design/stk_frame_seq.sv
// Purpose: walks the bytes of a multi-byte stack frame, one per enabled clock
// Assumes: start only while not busy
// Notes:   step is 0 in the start cycle, so the first byte costs no extra cycle
module stk_frame_seq (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       ce,
    // control
    input  wire logic       start,
    input  wire logic [2:0] len,
    // progress
    output logic            busy,
    output logic            active,
    output logic [2:0]      step,
    output logic            last
);

    logic [2:0] step_r;
    logic [2:0] len_r;
    logic       busy_r;

    // current position in the frame
    assign busy   = busy_r;
    assign active = start | busy_r;
    assign step   = start ? 3'h0 : step_r;
    assign last   = active & (step == ((start ? len : len_r) - 3'h1));

    // advance one byte per enabled clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_r <= 3'h0;
            len_r  <= 3'h0;
            busy_r <= 1'b0;
        end else if (ce) begin
            if (start) begin
                len_r <= len;
            end
            if (active) begin
                busy_r <= ~last;
                step_r <= last ? 3'h0 : step + 3'h1;
            end
        end
    end

endmodule // stk_frame_seq

// File: include/stk_pkg.sv
// Purpose: shared constants and carrier types for the stack pointer unit
// Assumes: one-byte stack accesses, one byte per enabled clock
// Notes:   stack pointer = fixed upper bits concatenated with a 6-bit moving part
package stk_pkg;

    // pointer layout and reset value
    localparam int          PTR_W         = 16;
    localparam int          LOW_W         = 6;
    localparam int          STACK_DEPTH   = 64;
    localparam logic [9:0]  PTR_FIXED_HI  = 10'h003;   // upper bits, forced by hardware
    localparam logic [5:0]  PTR_LOW_RESET = 6'h3F;     // top of stack
    localparam logic [15:0] PTR_RESET     = 16'h00FF;

    // frame lengths in bytes
    localparam logic [2:0]  LEN_NONE = 3'h0;
    localparam logic [2:0]  LEN_BYTE = 3'h1;
    localparam logic [2:0]  LEN_CALL = 3'h2;
    localparam logic [2:0]  LEN_IRQ  = 3'h5;

    // byte order of a context frame, lowest address last
    localparam logic [2:0]  IDX_RET_LO = 3'h0;
    localparam logic [2:0]  IDX_RET_HI = 3'h1;
    localparam logic [2:0]  IDX_X      = 3'h2;
    localparam logic [2:0]  IDX_A      = 3'h3;
    localparam logic [2:0]  IDX_FLAGS  = 3'h4;

    // interrupt priority bits inside the condition flags
    localparam int          FLG_I1_POS = 5;
    localparam int          FLG_I0_POS = 3;
    localparam logic [1:0]  PRIO_RESET = 2'h3;

    typedef enum logic [3:0] {
        OP_PUSH,     // push one register byte
        OP_POP,      // pop one register byte
        OP_POPCC,    // pop condition flags, restores priority
        OP_CALL,     // save return address
        OP_RET,      // restore return address
        OP_IRQ,      // save full context on interrupt entry
        OP_IRET,     // restore full context
        OP_RESTACK,  // reset_stack_instruction
        OP_LDSP      // load low six bits of the pointer
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [7:0] data;      // pushed byte or new pointer low six bits
        logic [1:0] irq_lvl;   // software priority of the routine entered
    } cmd_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0]  x;
        logic [7:0]  a;
        logic [7:0]  flags;
    } ctx_t;

endpackage

// File: test/seq_model.sv
// Purpose: instruction sequencer model feeding stack commands
// Assumes: tasks are entered at a falling edge
// Notes:   idle fields are scrambled so stale data is never mistaken for fresh
module seq_model (
    // clock and handshake
    input  wire logic     clk,
    input  wire logic     ready,
    // command out
    output logic          cmd_valid,
    output stk_pkg::cmd_t cmd,
    output stk_pkg::ctx_t ctx_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
        ctx_in = '0;
    end
    // hold everything until a rising edge sees ready, bounded wait
    task automatic issue(input stk_pkg::op_t o, input logic [7:0] d, input logic [1:0] l,
                         input stk_pkg::ctx_t x);
        int k;
        cmd_valid = 1'b1;
        cmd = '{o, d, l};
        ctx_in = x;
        for (k = 0; k < 20 && ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
    endtask
    // release the command lines
    task automatic idle();
        cmd_valid = 1'b0;
        cmd.data = ~cmd.data;
        ctx_in = ~ctx_in;
    endtask
endmodule // seq_model

// File: test/stk_chk.sv
// Purpose: port-level checks on the stack pointer unit
// Assumes: CE stays high while a frame or its completion is in flight
// Notes:   bound to every cpu_stack_pointer instance
module stk_chk (
    // clock and reset
    input wire logic          REF_CLK,
    input wire logic          ARST_N,
    input wire logic          CE,
    // command side
    input wire logic          CMD_VALID,
    input wire stk_pkg::cmd_t CMD,
    input wire logic          READY,
    // results
    input wire logic          DONE,
    input wire logic [7:0]    POP_DATA,
    input wire logic [15:0]   STACK_POINTER,
    input wire logic [1:0]    PRIO_LEVEL
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    // take qualifier and moving pointer bits
    wire       take = CE && CMD_VALID && READY;
    wire [5:0] lo   = STACK_POINTER[5:0];
    property p_fix; STACK_POINTER[15:6] == stk_pkg::PTR_FIXED_HI; endproperty
    property p_rst; $rose(ARST_N) |->
        STACK_POINTER == stk_pkg::PTR_RESET && PRIO_LEVEL == stk_pkg::PRIO_RESET; endproperty
    property p_push; take && CMD.op == stk_pkg::OP_PUSH |=> DONE && lo == $past(lo) - 6'h01;
    endproperty
    property p_pop; take && CMD.op == stk_pkg::OP_POP |=> DONE && lo == $past(lo) + 6'h01;
    endproperty
    property p_call; take && CMD.op == stk_pkg::OP_CALL |-> ##2 DONE && lo == $past(lo, 2) - 6'h02;
    endproperty
    property p_ret; take && CMD.op == stk_pkg::OP_RET |-> ##2 DONE && lo == $past(lo, 2) + 6'h02;
    endproperty
    // a context frame keeps the sequencer out for four clocks, done in the fifth
    property p_irq; take && CMD.op == stk_pkg::OP_IRQ |=> !READY [*4] ##1
        (READY && DONE && lo == $past(lo, 5) - 6'h05 && PRIO_LEVEL == $past(CMD.irq_lvl, 5));
    endproperty
    property p_restack; take && CMD.op == stk_pkg::OP_RESTACK |=>
        DONE && STACK_POINTER == stk_pkg::PTR_RESET; endproperty
    property p_ld; take && CMD.op == stk_pkg::OP_LDSP |=>
        STACK_POINTER == {stk_pkg::PTR_FIXED_HI, $past(CMD.data[5:0])}; endproperty
    property p_pcc; take && CMD.op == stk_pkg::OP_POPCC |=>
        DONE && PRIO_LEVEL == {POP_DATA[5], POP_DATA[3]}; endproperty
    a_fix: assert property (p_fix) else $error("fixed pointer bits moved");
    a_rst: assert property (p_rst) else $error("pointer not at top after reset");
    a_push: assert property (p_push) else $error("push step wrong");
    a_pop: assert property (p_pop) else $error("pop step wrong");
    a_call: assert property (p_call) else $error("call frame size wrong");
    a_ret: assert property (p_ret) else $error("return frame size wrong");
    a_irq: assert property (p_irq) else $error("interrupt frame wrong");
    a_restack: assert property (p_restack) else $error("stack reset wrong");
    a_ld: assert property (p_ld) else $error("pointer load wrong");
    a_pcc: assert property (p_pcc) else $error("priority not restored");
    c_irq: cover property (take && CMD.op == stk_pkg::OP_IRQ);
    c_wrap: cover property (take && CMD.op == stk_pkg::OP_PUSH && lo == 6'h00);
    c_pcc: cover property (take && CMD.op == stk_pkg::OP_POPCC);
endmodule // stk_chk

bind cpu_stack_pointer stk_chk u_chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(CE),
    .CMD_VALID(CMD_VALID), .CMD(CMD), .READY(READY), .DONE(DONE), .POP_DATA(POP_DATA),
    .STACK_POINTER(STACK_POINTER), .PRIO_LEVEL(PRIO_LEVEL));

// File: test/tb_top.sv
// Purpose: self-checking bench for the stack pointer unit
// Assumes: commands and CE change at the falling edge
// Notes:   expected results queue in issue order and retire on DONE
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0]    lo;
        logic [1:0]    pr;
        logic [7:0]    pd;
        logic [1:0]    k;   // bit 0 pop data, bit 1 context
        stk_pkg::ctx_t cx;
    } note_t;
    logic          REF_CLK = 1'b0;
    logic          ARST_N = 1'b0;
    logic          CE = 1'b1;
    logic          CMD_VALID, READY, DONE;
    stk_pkg::cmd_t CMD;
    stk_pkg::ctx_t CTX_IN, CTX_OUT, x, co;
    logic [7:0]    POP_DATA, d;
    logic [15:0]   STACK_POINTER;
    logic [1:0]    PRIO_LEVEL, pr, lvl, sv;
    note_t         notes[$];
    note_t         n;
    int            errors = 0;
    int            n_checks = 0;
    int            cyc = 0;
    always #25 REF_CLK = ~REF_CLK;
    cpu_stack_pointer dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(CE), .CMD_VALID(CMD_VALID),
        .CMD(CMD), .CTX_IN(CTX_IN), .READY(READY), .DONE(DONE), .POP_DATA(POP_DATA),
        .CTX_OUT(CTX_OUT), .STACK_POINTER(STACK_POINTER), .PRIO_LEVEL(PRIO_LEVEL));
    seq_model u_seq (.clk(REF_CLK), .ready(READY), .cmd_valid(CMD_VALID), .cmd(CMD),
        .ctx_in(CTX_IN));
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // note first so a fast DONE always finds its entry
    task automatic go(input stk_pkg::op_t o, input logic [7:0] dt, input logic [5:0] lo,
                      input logic [7:0] pd, input logic [1:0] k);
        notes.push_back('{lo, pr, pd, k, co});
        u_seq.issue(o, dt, lvl, x);
    endtask
    task automatic drain(input string t);
        int i;
        u_seq.idle();
        for (i = 0; i < 20 && notes.size() > 0; i++) @(negedge REF_CLK);
        check("pending", 40'(notes.size()), 40'h0);
        $display("test %s done", t);
    endtask
    // retire the oldest note on every completion, outputs settled mid-cycle
    always @(negedge REF_CLK) begin
        if (DONE === 1'b1 && notes.size() == 0) check("spare done", 40'h1, 40'h0);
        else if (DONE === 1'b1) begin
            n = notes.pop_front();
            check("pointer", 40'(STACK_POINTER), 40'({stk_pkg::PTR_FIXED_HI, n.lo}));
            check("priority", 40'(PRIO_LEVEL), 40'(n.pr));
            if (n.k[0]) check("pop data", 40'(POP_DATA), 40'(n.pd));
            if (n.k[1]) check("context", CTX_OUT, n.cx);
        end
    end
    // hang guard, far above the few dozen clocks needed
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc > 3000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(2321));
        pr = 2'h3;
        co = '0;
        x = '0;
        lvl = 2'h0;
        repeat (3) @(negedge REF_CLK);
        ARST_N = 1'b1;
        check("reset", 40'({READY, PRIO_LEVEL, STACK_POINTER}), 40'h7_00FF);
        d = 8'($urandom);
        go(stk_pkg::OP_PUSH, d, 6'h3E, 8'h00, 2'h0);
        go(stk_pkg::OP_POP, 8'h00, 6'h3F, d, 2'h1);
        drain("push_pop");
        go(stk_pkg::OP_LDSP, {2'($urandom), 6'h00}, 6'h00, 8'h00, 2'h0);
        go(stk_pkg::OP_PUSH, ~d, 6'h3F, 8'h00, 2'h0);
        go(stk_pkg::OP_POP, 8'h00, 6'h00, ~d, 2'h1);
        drain("wrap");
        x = 40'({$urandom, $urandom});
        go(stk_pkg::OP_RESTACK, 8'h00, 6'h3F, 8'h00, 2'h0);
        go(stk_pkg::OP_CALL, 8'h00, 6'h3D, 8'h00, 2'h0);
        co.pc = x.pc;
        go(stk_pkg::OP_RET, 8'h00, 6'h3F, 8'h00, 2'h2);
        drain("call");
        d = 8'($urandom);
        go(stk_pkg::OP_PUSH, d, 6'h3E, 8'h00, 2'h0);
        pr = {d[stk_pkg::FLG_I1_POS], d[stk_pkg::FLG_I0_POS]};
        go(stk_pkg::OP_POPCC, 8'h00, 6'h3F, d, 2'h1);
        drain("flags");
        // mid-run reset must undo the restored priority and the popped byte
        ARST_N = 1'b0;
        @(negedge REF_CLK);
        ARST_N = 1'b1;
        pr = 2'h3;
        check("mid reset", 40'({DONE, READY, PRIO_LEVEL, POP_DATA, STACK_POINTER}),
              40'h7_00_00FF);
        // a push held against a low enable must leave no trace at all
        CE = 1'b0;
        u_seq.issue(stk_pkg::OP_PUSH, d, 2'h0, x);
        repeat (2) @(negedge REF_CLK);
        check("frozen", 40'({DONE, READY, STACK_POINTER}), 40'h1_00FF);
        drain("reset_freeze");
        CE = 1'b1;
        // context frame, low return byte read back at the top
        repeat (2) begin
            x = 40'({$urandom, $urandom});
            lvl = 2'($urandom);
            co = x;
            co.flags[stk_pkg::FLG_I1_POS] = pr[1];
            co.flags[stk_pkg::FLG_I0_POS] = pr[0];
            sv = pr;
            pr = lvl;
            go(stk_pkg::OP_IRQ, 8'h00, 6'h3A, 8'h00, 2'h0);
            go(stk_pkg::OP_LDSP, 8'h3E, 6'h3E, 8'h00, 2'h0);
            go(stk_pkg::OP_POP, 8'h00, 6'h3F, x.pc[7:0], 2'h1);
            go(stk_pkg::OP_LDSP, 8'h3A, 6'h3A, 8'h00, 2'h0);
            pr = sv;
            go(stk_pkg::OP_IRET, 8'h00, 6'h3F, 8'h00, 2'h2);
            drain("irq");
        end
        end_of_test();
    end
endmodule // tb_top
